// ==== rtl/uarx_pkg.sv ====
// Purpose: Shared constants and types for the UART receive path.
// Assumes: One 20 MHz clock; all control inputs synchronous to it.
// Notes:   Every timing count, width and receiver reset value lives here; the tick divider resets to zero in its own file.

// ****************************************************************
// Package
// ****************************************************************
package uarx_pkg;

  // Oversampling: sixteen ticks per bit, three samples at mid-bit.
  localparam int         OS_RATE     = 16;
  localparam logic [3:0] OS_LAST     = 4'hF;
  localparam logic [3:0] OS_SAMP_A   = 4'h7;
  localparam logic [3:0] OS_SAMP_B   = 4'h8;
  localparam logic [3:0] OS_SAMP_C   = 4'h9;

  // Index of the last data bit for 8-bit and 9-bit words.
  localparam logic [3:0] LAST_BIT_8  = 4'h7;
  localparam logic [3:0] LAST_BIT_9  = 4'h8;

  // Width of the baud divisor and of a received word.
  localparam int         DIV_W       = 8;
  localparam int         WORD_W      = 9;
  localparam int         FIFO_DEPTH  = 2;

  // Reset values of the visible flags and of the pin edge detector.
  localparam logic       RST_IDLE    = 1'b1;
  localparam logic       RST_IRQ_N   = 1'b1;
  localparam logic       RST_PIN     = 1'b1;

  // Receiver sequencer states.
  typedef enum logic [4:0] {
    ST_HUNT      = 5'h01,
    ST_START     = 5'h02,
    ST_DATA      = 5'h04,
    ST_STOP      = 5'h08,
    ST_WAIT_HIGH = 5'h10
  } uarx_state_type;

  // One FIFO entry: the word with the flags that travel with it.
  typedef struct packed {
    logic [WORD_W-1:0] word;
    logic              ferr;
    logic              perr;
    logic              nf;
    logic              valid;
  } uarx_entry_type;

  // Complete state of the receiver; the tick divider keeps its own.
  typedef struct packed {
    uarx_state_type                   st;
    logic [3:0]                       os_cnt;
    logic [3:0]                       bit_cnt;
    logic [1:0]                       samp;
    logic                             noise;
    logic [WORD_W-1:0]                shreg;
    uarx_entry_type [FIFO_DEPTH-1:0]  fifo;
    logic                             ovr;
    logic                             idle;
    logic                             armed;
    logic                             irq_n;
    logic                             pin_prev;
    logic                             claim;
  } uarx_rec_type;

  localparam uarx_rec_type RST_REC = '{
    st:       ST_HUNT,
    os_cnt:   4'h0,
    bit_cnt:  4'h0,
    samp:     2'h0,
    noise:    1'b0,
    shreg:    9'h000,
    fifo:     '0,
    ovr:      1'b0,
    idle:     RST_IDLE,
    armed:    1'b0,
    irq_n:    RST_IRQ_N,
    pin_prev: RST_PIN,
    claim:    1'b0
  };

endpackage

// ==== rtl/uarx_tick_gen.sv ====
// Purpose: Oversampling tick divider for the UART receive path.
// Assumes: Divisor is stable while the receiver runs.
// Notes:   One tick every divisor plus one clocks, at 16x the baud.

module uarx_tick_gen
  import uarx_pkg::*;
(
  // Clock and reset.
  input  wire logic                       clk_i,
  input  wire logic                       nrst_i,
  // Control.
  input  wire logic                       run_i,
  input  wire logic [uarx_pkg::DIV_W-1:0] div_i,
  // Tick out.
  output logic                            tick_o
);

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             tick;
  } uarx_tick_rec_type;

  uarx_tick_rec_type q;
  uarx_tick_rec_type d;

  // Count down and reload; a stopped divider restarts a full period.
  always_comb begin
    d      = q;
    d.tick = 1'b0;
    if (!run_i) begin
      d.cnt = div_i;
    end else if (q.cnt == '0) begin
      d.cnt  = div_i;
      d.tick = 1'b1;
    end else begin
      d.cnt = DIV_W'(q.cnt - 1'b1);
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick_o = q.tick;

endmodule

// ==== rtl/uarx_receiver.sv ====
// Purpose: Receive half of a UART with a two-word FIFO and status flags.
// Assumes: Software strobes are one-cycle pulses synchronous to clk_i.
// Notes:   All outputs come straight from the state record flip-flops.
//          Sampling pauses while the UART clock is off; only the wake
//          detector keeps watching the pin, on the plain clock.

module uarx_receiver
  import uarx_pkg::*;
(
  // Clock and reset.
  input  wire logic                       clk_i,
  input  wire logic                       nrst_i,

  // Configuration bits.
  input  wire logic                       uart_on_bit_i,
  input  wire logic                       rx_enable_bit_i,
  input  wire logic                       word_length_sel_i,
  input  wire logic                       parity_on_bit_i,
  input  wire logic                       parity_type_bit_i,
  input  wire logic                       addr_detect_enable_i,
  input  wire logic                       wake_enable_bit_i,
  input  wire logic                       rx_irq_enable_i,
  input  wire logic                       uart_clk_off_i,
  input  wire logic [uarx_pkg::DIV_W-1:0] baud_divisor_reg_i,

  // Software access strobes.
  input  wire logic                       status_access_i,
  input  wire logic                       data_read_i,

  // Serial pin.
  input  wire logic                       shared_serial_pin_i,
  output logic                            pin_claim_o,

  // Data buffer head.
  output logic [7:0]                      serial_data_buffer_o,
  output logic                            rx_ninth_bit_o,

  // Status flags.
  output logic                            rx_avail_flag_o,
  output logic                            overrun_flag_o,
  output logic                            frame_err_flag_o,
  output logic                            noise_flag_o,
  output logic                            parity_err_flag_o,
  output logic                            rx_idle_flag_o,

  // Interrupt request, active low pulse.
  output logic                            irq_n_o
);

  // ****************************************************************
  // Declarations
  // ****************************************************************

  // Sequencer record and the helpers that feed its next state.
  uarx_rec_type   q;
  uarx_rec_type   d;
  logic           tick;
  logic           tick_ok;
  logic           run;
  logic [2:0]     smp3;
  logic           vote;
  logic           smp_noise;
  logic [3:0]     last_bit;
  logic           par_bad;
  logic           top_bit;
  logic           frame_done;
  logic           push_irq;
  uarx_entry_type new_entry;

  // ****************************************************************
  // Oversampling tick
  // ****************************************************************

  // The divider only runs while the receiver may sample; a stopped
  // UART clock pauses reception rather than corrupting it.
  assign run = uart_on_bit_i & rx_enable_bit_i & ~uart_clk_off_i;

  uarx_tick_gen u_tick (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .run_i  (run),
    .div_i  (baud_divisor_reg_i),
    .tick_o (tick)
  );

  // A tick counted just before the divider stops still sits in its
  // register; gating it here keeps a stopped clock from advancing or
  // finishing a frame.
  assign tick_ok = tick & run;

  // ****************************************************************
  // Sample vote and word checks
  // ****************************************************************

  // The third sample is the live pin, so the vote is ready at mid-bit.
  assign smp3      = {q.samp, shared_serial_pin_i};
  assign vote      = (smp3[0] & smp3[1]) | (smp3[0] & smp3[2]) |
                     (smp3[1] & smp3[2]);

  // Noise means the three samples of one bit disagree.
  assign smp_noise = ~((&smp3) | (~|smp3));

  // Parity bit is part of the word, so the last bit index covers it.
  assign last_bit  = word_length_sel_i ? LAST_BIT_9 : LAST_BIT_8;

  // Even parity wants an even count of ones over the word and parity.
  assign par_bad   = parity_on_bit_i &
                     ((^q.shreg) != parity_type_bit_i);

  // Address qualifier looks at the top received bit of the word.
  assign top_bit   = word_length_sel_i ? q.shreg[8] : q.shreg[7];

  // Receive interrupt qualifier shared by both FIFO slots.
  assign push_irq  = rx_irq_enable_i &
                     (~addr_detect_enable_i | top_bit);

  // A frame ends at the vote point of its single stop bit.
  assign frame_done = tick_ok & (q.st == ST_STOP) &
                      (q.os_cnt == OS_SAMP_C);

  // Entry that a finished frame would push; a break yields a zero word with the frame error set.
  always_comb begin
    new_entry       = '0;
    new_entry.word  = word_length_sel_i ? q.shreg :
                      {1'b0, q.shreg[7:0]};
    new_entry.ferr  = ~vote;
    new_entry.perr  = par_bad;
    new_entry.nf    = q.noise | smp_noise;
    new_entry.valid = 1'b1;
  end

  // ****************************************************************
  // Next state
  // ****************************************************************

  // One process builds the whole next state: sequencer, FIFO, flags
  // and interrupt pulse, in a fixed order so that a stored frame and its
  // flag sets land after the read pop and clear of the same cycle.
  always_comb begin
    d          = q;
    d.irq_n    = RST_IRQ_N;
    d.pin_prev = shared_serial_pin_i;
    d.claim    = uart_on_bit_i & rx_enable_bit_i;

    // Status access arms the clear; the next data read completes it.
    if (status_access_i) begin
      d.armed = 1'b1;
    end

    // A data read pops the head when one is stored; the second word slides down.
    // A read on an empty buffer leaves the FIFO unchanged.
    if (data_read_i) begin
      if (q.fifo[0].valid) begin
        d.fifo[0] = q.fifo[1];
        d.fifo[1] = '0;
      end
      if (q.armed) begin
        d.ovr   = 1'b0;
        d.armed = 1'b0;
      end
    end

    // Bit sequencer, advanced only on oversampling ticks.
    if (tick_ok) begin
      unique case (q.st)
        ST_HUNT: begin
          d.idle = 1'b1;
          // The raw pin starts a frame; the start vote weeds out glitches.
          if (!shared_serial_pin_i) begin
            d.st      = ST_START;
            d.os_cnt  = 4'h0;
            d.noise   = 1'b0;
            d.shreg   = '0;
            d.idle    = 1'b0;
          end
        end

        ST_START: begin
          d.os_cnt = 4'(q.os_cnt + 4'h1);
          if (q.os_cnt == OS_SAMP_A || q.os_cnt == OS_SAMP_B) begin
            d.samp = {q.samp[0], shared_serial_pin_i};
          end
          if (q.os_cnt == OS_SAMP_C) begin
            d.noise = q.noise | smp_noise;
            // A start bit that votes high was a glitch.
            if (vote) begin
              d.st   = ST_HUNT;
              d.idle = 1'b1;
            end
          end
          if (q.os_cnt == OS_LAST) begin
            d.st      = ST_DATA;
            d.bit_cnt = 4'h0;
          end
        end

        ST_DATA: begin
          d.os_cnt = 4'(q.os_cnt + 4'h1);
          if (q.os_cnt == OS_SAMP_A || q.os_cnt == OS_SAMP_B) begin
            d.samp = {q.samp[0], shared_serial_pin_i};
          end
          if (q.os_cnt == OS_SAMP_C) begin
            d.noise             = q.noise | smp_noise;
            d.shreg[q.bit_cnt]  = vote;
          end
          if (q.os_cnt == OS_LAST) begin
            if (q.bit_cnt == last_bit) begin
              d.st = ST_STOP;
            end else begin
              d.bit_cnt = 4'(q.bit_cnt + 4'h1);
            end
          end
        end

        ST_STOP: begin
          d.os_cnt = 4'(q.os_cnt + 4'h1);
          if (q.os_cnt == OS_SAMP_A || q.os_cnt == OS_SAMP_B) begin
            d.samp = {q.samp[0], shared_serial_pin_i};
          end
          if (q.os_cnt == OS_SAMP_C) begin
            d.idle = 1'b1;
            // A low stop level must clear before the next hunt.
            d.st   = vote ? ST_HUNT : ST_WAIT_HIGH;
          end
        end

        ST_WAIT_HIGH: begin
          d.idle = 1'b1;
          // A long break keeps the line low; nothing is hunted until it rises.
          if (shared_serial_pin_i) begin
            d.st = ST_HUNT;
          end
        end
      endcase
    end

    // Finished frame: store it or report an overrun.
    if (frame_done) begin
      if (!d.fifo[0].valid) begin
        d.fifo[0] = new_entry;
        if (push_irq) begin
          d.irq_n = 1'b0;
        end
      end else if (!d.fifo[1].valid) begin
        d.fifo[1] = new_entry;
        if (push_irq) begin
          d.irq_n = 1'b0;
        end
      end else begin
        // FIFO kept intact; the shift register already holds the new word.
        d.ovr = 1'b1;
        if (rx_irq_enable_i) begin
          d.irq_n = 1'b0;
        end
      end
    end

    // Wake-up from a stopped clock needs no flag, only the pulse.
    // The edge detector resets to the idle line level, so reset makes no edge.
    if (uart_clk_off_i && wake_enable_bit_i && rx_irq_enable_i &&
        uart_on_bit_i && rx_enable_bit_i &&
        q.pin_prev && !shared_serial_pin_i) begin
      d.irq_n = 1'b0;
    end

    // Receiver disabled: drop any frame in flight, stay idle.
    if (!rx_enable_bit_i) begin
      d.st     = ST_HUNT;
      d.os_cnt = 4'h0;
      d.idle   = 1'b1;
    end

    // UART disabled: flush the buffer and every flag.
    if (!uart_on_bit_i) begin
      d.st     = ST_HUNT;
      d.os_cnt = 4'h0;
      d.fifo   = '0;
      d.ovr    = 1'b0;
      d.armed  = 1'b0;
      d.idle   = 1'b1;
      d.irq_n  = RST_IRQ_N;
    end

    // Reset is synchronous, so it simply overrides the next state.
    if (!nrst_i) begin
      d = RST_REC;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************

  // Single register stage for the whole record.
  // Reset is folded into the next state, so this stage has no branch.
  always_ff @(posedge clk_i) begin
    q <= d;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // Flags come from the head entry, so each word carries its own errors
  // and software can read them before taking the data.
  assign serial_data_buffer_o = q.fifo[0].word[7:0];
  assign rx_ninth_bit_o       = q.fifo[0].word[8];
  assign rx_avail_flag_o      = q.fifo[0].valid;
  assign frame_err_flag_o     = q.fifo[0].ferr;
  assign parity_err_flag_o    = q.fifo[0].perr;
  assign noise_flag_o         = q.fifo[0].nf;
  // Overrun lives outside the entries: it survives pops until the
  // status access then data read sequence clears it.
  assign overrun_flag_o       = q.ovr;
  assign rx_idle_flag_o       = q.idle;
  assign irq_n_o              = q.irq_n;
  assign pin_claim_o          = q.claim;

endmodule

// ==== verification/uarx_receiver_props.sv ====
// Purpose: Port level checks for the UART receive path.
// Assumes: One clock; nrst_i is synchronous and active low.
// Notes:   Bound to every receiver instance below.

// ****************************************************************
// Checker
// ****************************************************************
module uarx_receiver_props (
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  // Controls and pin.
  input  wire logic       uart_on_bit_i,
  input  wire logic       rx_enable_bit_i,
  input  wire logic       word_length_sel_i,
  input  wire logic       addr_detect_enable_i,
  input  wire logic       rx_irq_enable_i,
  input  wire logic       shared_serial_pin_i,
  // Outputs watched.
  input  wire logic       pin_claim_o,
  input  wire logic [7:0] serial_data_buffer_o,
  input  wire logic       rx_avail_flag_o,
  input  wire logic       overrun_flag_o,
  input  wire logic       frame_err_flag_o,
  input  wire logic       noise_flag_o,
  input  wire logic       rx_idle_flag_o,
  input  wire logic       irq_n_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // All checks share the one clock and its reset.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  a_irq_one_cycle: assert property (!irq_n_o |=> irq_n_o)
    else $error("irq held low for more than one cycle");
  a_irq_needs_en: assert property (!irq_n_o |-> $past(rx_irq_enable_i))
    else $error("irq raised without receive enable");
  a_push_irq: assert property ($rose(rx_avail_flag_o) && $past(rx_irq_enable_i)
    && !$past(addr_detect_enable_i) |-> !irq_n_o) else $error("no irq on stored word");
  a_addr_gate: assert property ($rose(rx_avail_flag_o) && $past(addr_detect_enable_i)
    && !$past(word_length_sel_i) && !serial_data_buffer_o[7] |-> irq_n_o)
    else $error("irq on data word in address mode");
  a_claim_follow: assert property ($past(nrst_i)
    |-> pin_claim_o == $past(uart_on_bit_i && rx_enable_bit_i)) else $error("claim wrong");
  a_off_flushes: assert property (!uart_on_bit_i |=> !rx_avail_flag_o && !overrun_flag_o
    && !frame_err_flag_o && !noise_flag_o && rx_idle_flag_o) else $error("disable no flush");
  a_flag_has_word: assert property (noise_flag_o || frame_err_flag_o |-> rx_avail_flag_o)
    else $error("entry flag without a stored word");
  a_ovr_when_full: assert property ($rose(overrun_flag_o) |-> $past(rx_avail_flag_o))
    else $error("overrun with empty buffer");
  a_idle_on_start: assert property ($fell(rx_idle_flag_o) |-> !$past(shared_serial_pin_i))
    else $error("idle dropped without a start level");

  // Main scenarios reached.
  c_overrun: cover property ($rose(overrun_flag_o));
  c_frame_err: cover property ($rose(frame_err_flag_o));
  c_irq: cover property ($fell(irq_n_o));
endmodule

bind uarx_receiver uarx_receiver_props props_u (
  .clk_i(clk_i), .nrst_i(nrst_i), .uart_on_bit_i(uart_on_bit_i),
  .rx_enable_bit_i(rx_enable_bit_i), .word_length_sel_i(word_length_sel_i),
  .addr_detect_enable_i(addr_detect_enable_i), .rx_irq_enable_i(rx_irq_enable_i),
  .shared_serial_pin_i(shared_serial_pin_i), .pin_claim_o(pin_claim_o),
  .serial_data_buffer_o(serial_data_buffer_o), .rx_avail_flag_o(rx_avail_flag_o),
  .overrun_flag_o(overrun_flag_o), .frame_err_flag_o(frame_err_flag_o),
  .noise_flag_o(noise_flag_o), .rx_idle_flag_o(rx_idle_flag_o), .irq_n_o(irq_n_o)
);

// ==== verification/uarx_line_model.sv ====
// Purpose: Remote transmitter driving the serial line.
// Assumes: Bit time in clocks matches the receiver's divisor.
// Notes:   Line rests high between frames, as a UART line does.

// ****************************************************************
// Line model
// ****************************************************************
module uarx_line_model (
  // Clock.
  input  wire logic clk_i,
  // Serial line towards the receiver.
  output logic      pin_o
);
  timeunit 1ns;
  timeprecision 1ns;

  int bit_clks = 32;

  // Idle level until the first frame.
  initial pin_o = 1'b1;

  // Holds one level for a count of clocks; called just after an edge, it
  // returns just after one too, so checks that follow never race the clock.
  task automatic hold(input logic v, input int c);
    pin_o = v;
    repeat (c) @(posedge clk_i);
    #2;
  endtask

  // Start, n data bits from bit 0 up, stop level, one idle bit.
  // Index g flips one tick mid-bit, so the vote still wins but noise shows.
  task automatic frame(input logic [8:0] w, input int n, input logic stp, input int g);
    hold(1'b0, bit_clks);
    for (int i = 0; i < n; i++) begin
      if (i == g) begin
        hold(w[i], bit_clks / 2);
        hold(!w[i], bit_clks / 16);
        hold(w[i], bit_clks / 2 - bit_clks / 16);
      end else begin
        hold(w[i], bit_clks);
      end
    end
    hold(stp, bit_clks);
    hold(1'b1, bit_clks);
  endtask
endmodule

// ==== verification/test_uarx_receiver.sv ====
// Purpose: Self-checking bench for the UART receive path.
// Assumes: Divisor 1, so one bit lasts 32 clocks.
// Notes:   Random words come from a fixed-seed shift register.

// ****************************************************************
// Bench
// ****************************************************************
module test_uarx_receiver;
  timeunit 1ns;
  timeprecision 1ns;
  import uarx_pkg::*;

  logic       clk_i, nrst_i, uart_on_bit_i, rx_enable_bit_i, word_length_sel_i;
  logic       parity_on_bit_i, parity_type_bit_i, addr_detect_enable_i, wake_enable_bit_i;
  logic       rx_irq_enable_i, uart_clk_off_i, status_access_i, data_read_i;
  logic [7:0] baud_divisor_reg_i, serial_data_buffer_o;
  logic       shared_serial_pin_i, pin_claim_o, rx_ninth_bit_o, rx_avail_flag_o;
  logic       overrun_flag_o, frame_err_flag_o, noise_flag_o, parity_err_flag_o;
  logic       rx_idle_flag_o, irq_n_o;
  logic [15:0] lfsr;
  logic [8:0] w;
  int         errors = 0, check_count = 0, irq_cnt = 0, n;

  uarx_line_model line_u (.clk_i(clk_i), .pin_o(shared_serial_pin_i));
  uarx_receiver dut_u (
    .clk_i(clk_i), .nrst_i(nrst_i), .uart_on_bit_i(uart_on_bit_i),
    .rx_enable_bit_i(rx_enable_bit_i), .word_length_sel_i(word_length_sel_i),
    .parity_on_bit_i(parity_on_bit_i), .parity_type_bit_i(parity_type_bit_i),
    .addr_detect_enable_i(addr_detect_enable_i), .wake_enable_bit_i(wake_enable_bit_i),
    .rx_irq_enable_i(rx_irq_enable_i), .uart_clk_off_i(uart_clk_off_i),
    .baud_divisor_reg_i(baud_divisor_reg_i), .status_access_i(status_access_i),
    .data_read_i(data_read_i), .shared_serial_pin_i(shared_serial_pin_i),
    .pin_claim_o(pin_claim_o), .serial_data_buffer_o(serial_data_buffer_o),
    .rx_ninth_bit_o(rx_ninth_bit_o), .rx_avail_flag_o(rx_avail_flag_o),
    .overrun_flag_o(overrun_flag_o), .frame_err_flag_o(frame_err_flag_o),
    .noise_flag_o(noise_flag_o), .parity_err_flag_o(parity_err_flag_o),
    .rx_idle_flag_o(rx_idle_flag_o), .irq_n_o(irq_n_o)
  );

  // 20 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // Counts interrupt pulses; a level stuck low would count every cycle.
  always @(posedge clk_i) if (irq_n_o === 1'b0) irq_cnt <= irq_cnt + 1;

  task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic step(input int c);
    repeat (c) @(posedge clk_i);
    #2;
  endtask

  // Optional status access, then a data read, one cycle apart.
  task automatic pop(input logic sa);
    status_access_i = sa;
    step(1);
    status_access_i = 1'b0;
    data_read_i = 1'b1;
    step(1);
    data_read_i = 1'b0;
    step(1);
  endtask

  // Head word and its flags: avail, frame, parity, noise.
  task automatic head(input logic [8:0] e, input logic [3:0] f);
    chk("data", {1'b0, serial_data_buffer_o}, {1'b0, e[7:0]});
    chk("ninth", rx_ninth_bit_o, e[8]);
    chk("flags", {rx_avail_flag_o, frame_err_flag_o, parity_err_flag_o, noise_flag_o}, f);
  endtask

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Parity over every received bit, the parity bit included.
  function automatic logic exp_perr(input logic [8:0] e, input logic nine, input logic odd);
    return (nine ? ^e : ^e[7:0]) != odd;
  endfunction

  task automatic test_done();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    #3000000;
    errors++;
    test_done();
  end

  // Main sequence.
  initial begin
    {uart_on_bit_i, rx_enable_bit_i, word_length_sel_i, parity_on_bit_i} = 4'h0;
    {parity_type_bit_i, addr_detect_enable_i, wake_enable_bit_i} = 3'h0;
    {rx_irq_enable_i, uart_clk_off_i, status_access_i, data_read_i} = 4'h0;
    baud_divisor_reg_i = 8'h01;
    lfsr = 16'h0005;
    nrst_i = 1'b0;
    step(6);
    nrst_i = 1'b1;
    step(1);
    chk("reset", {rx_idle_flag_o, irq_n_o, rx_avail_flag_o}, 9'h006);
    {uart_on_bit_i, rx_enable_bit_i, rx_irq_enable_i} = 3'h7;
    step(2);
    chk("claim", pin_claim_o, 1'b1);
    // Random words in every length and parity setting.
    for (int k = 0; k < 16; k++) begin
      lfsr = lfsr_next(lfsr);
      {word_length_sel_i, parity_on_bit_i, parity_type_bit_i} = k[2:0];
      w = word_length_sel_i ? lfsr[8:0] : {1'b0, lfsr[7:0]};
      n = irq_cnt;
      line_u.frame(w, word_length_sel_i ? 9 : 8, 1'b1, -1);
      head(w, {2'b10, parity_on_bit_i && exp_perr(w, word_length_sel_i, k[0]), 1'b0});
      chk("irq", 9'(irq_cnt - n), 9'h001);
      pop(1'b1);
      chk("avail", rx_avail_flag_o, 1'b0);
    end
    {word_length_sel_i, parity_on_bit_i} = 2'h0;
    // Disturbed sample in bit 0, idle seen low mid-frame.
    fork
      line_u.frame(9'h0A5, 8, 1'b1, 0);
      begin
        step(96);
        chk("idle", rx_idle_flag_o, 1'b0);
      end
    join
    head(9'h0A5, 4'b1001);
    pop(1'b1);
    // Three words into a two-word buffer.
    n = irq_cnt;
    for (int k = 0; k < 3; k++) line_u.frame(9'(k + 'h31), 8, 1'b1, -1);
    chk("ovr", overrun_flag_o, 1'b1);
    chk("irqs", 9'(irq_cnt - n), 9'h003);
    head(9'h031, 4'b1000);
    pop(1'b0);
    head(9'h032, 4'b1000);
    chk("ovr", overrun_flag_o, 1'b1);
    pop(1'b1);
    chk("ovr", {overrun_flag_o, rx_avail_flag_o}, 9'h000);
    // Long break, then a low stop bit on a data word.
    line_u.hold(1'b0, 640);
    line_u.hold(1'b1, 64);
    head(9'h000, 4'b1100);
    chk("idle", rx_idle_flag_o, 1'b1);
    pop(1'b1);
    chk("avail", rx_avail_flag_o, 1'b0);
    line_u.frame(9'h05A, 8, 1'b0, -1);
    head(9'h05A, 4'b1100);
    pop(1'b1);
    // Address detect against enable, top bit and length.
    {addr_detect_enable_i, parity_on_bit_i} = 2'h2;
    for (int k = 0; k < 8; k++) begin
      {word_length_sel_i, rx_irq_enable_i} = {k[2], k[1]};
      w = k[2] ? {k[0], !k[0], 7'h15} : {1'b0, k[0], 7'h15};
      n = irq_cnt;
      line_u.frame(w, 8 + k[2], 1'b1, -1);
      chk("addr irq", 9'(irq_cnt - n), {8'h00, k[0] & k[1]});
      pop(1'b1);
    end
    // Falling pin edge while the clock is off.
    {addr_detect_enable_i, word_length_sel_i, rx_irq_enable_i} = 3'h1;
    {wake_enable_bit_i, uart_clk_off_i} = 2'h3;
    n = irq_cnt;
    line_u.hold(1'b0, 4);
    line_u.hold(1'b1, 4);
    chk("wake", {9'(irq_cnt - n)}, 9'h001);
    chk("avail", rx_avail_flag_o, 1'b0);
    {wake_enable_bit_i, uart_clk_off_i} = 2'h0;
    step(2);
    // Disable flushes a stored word; receiver off ignores the line.
    line_u.frame(9'h077, 8, 1'b1, -1);
    chk("stored", rx_avail_flag_o, 1'b1);
    uart_on_bit_i = 1'b0;
    step(2);
    chk("flush", {rx_avail_flag_o, rx_idle_flag_o}, 9'h001);
    {uart_on_bit_i, rx_enable_bit_i} = 2'h2;
    step(2);
    line_u.frame(9'h066, 8, 1'b1, -1);
    chk("off", {rx_avail_flag_o, pin_claim_o}, 9'h000);
    test_done();
  end
endmodule
